/* dspt_pkg.sv */
/*
 * Constants, register map and field layout of the dual-slope PWM timer.
 * Assumes an APB master with 32-bit data and one 8-bit register per aligned word.
 */
// Summary of operation
// - Mode selector 8 or 9 runs dual-slope counting, zero up to TOP and back.
// - TOP is the capture/top register in mode 8, compare A in mode 9.
// - Counter sits at TOP for one tick, then counts downward.
// - Non-inverting clears output on up-match, sets on down-match; inverting reversed.
// - Output-mode field two gives non-inverted PWM, three gives inverted PWM.
// - TOP may range from 0x0003 (2-bit) up to the 16-bit maximum.
// - Active compare values load from buffers at BOTTOM; overflow flag set then.
// - The register defining TOP gets its compare-A or capture flag set at TOP.
// - Compare-match flag sets whenever counter equals active compare value, either direction.
// - Software keeps TOP at or above compare values; else that channel never matches.
// - Compare output reaches the pin only while its direction bit selects output.
// - Compare at BOTTOM holds output low, at TOP high; inverted mode opposite.
// - Timer tick comes from the clock through divide ratios 1, 8, 64, 256, 1024.
// - Fully synchronous; the tick is only an enable for counting, flags, buffers.
// - Counter, compares and capture are 16-bit, reached by bytes via one temp byte.
// - Low-byte write loads temp high byte and low byte together in one cycle.
// - Counter or capture low-byte read copies the register's high byte into temp in that cycle.
// - Compare high-byte reads return directly, leaving the temp byte untouched.
// - One period lasts twice TOP ticks: clock over two times prescale times TOP.
// - Field value one with top mode bit set toggles output A; B reserved.
package dspt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_CNT_L  = 8'h08;
	localparam logic [7:0] OFS_CNT_H  = 8'h0c;
	localparam logic [7:0] OFS_CMPA_L = 8'h10;
	localparam logic [7:0] OFS_CMPA_H = 8'h14;
	localparam logic [7:0] OFS_CMPB_L = 8'h18;
	localparam logic [7:0] OFS_CMPB_H = 8'h1c;
	localparam logic [7:0] OFS_CAP_L  = 8'h20;
	localparam logic [7:0] OFS_CAP_H  = 8'h24;
	localparam logic [7:0] OFS_FLAGS  = 8'h28;
	localparam logic [7:0] OFS_DIR    = 8'h2c;

	// Writable bits and reset values
	localparam logic [7:0] CTRL_A_MASK = 8'hf3;
	localparam logic [7:0] CTRL_B_MASK = 8'h1f;
	localparam logic [7:0] CTRL_A_RST  = 8'h00;
	localparam logic [7:0] CTRL_B_RST  = 8'h00;

	// Field positions
	localparam int MODE_A_POS  = 6;
	localparam int MODE_B_POS  = 4;
	localparam int MSEL_LO_POS = 0;
	localparam int MSEL_HI_POS = 3;
	localparam int CSEL_POS    = 0;
	localparam int FLAG_OVF    = 0;
	localparam int FLAG_CMPA   = 1;
	localparam int FLAG_CMPB   = 2;
	localparam int FLAG_CAP    = 3;
	localparam int DIR_A_POS   = 0;
	localparam int DIR_B_POS   = 1;

	// Waveform modes handled here
	localparam logic [3:0] MODE_TOP_CAP  = 4'h8;
	localparam logic [3:0] MODE_TOP_CMPA = 4'h9;

	// Output-mode field codes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_NONINV = 2'h2;
	localparam logic [1:0] OM_INV    = 2'h3;

	localparam logic [15:0] BOTTOM  = 16'h0000;
	localparam logic [15:0] TOP_MIN = 16'h0003;

	// Prescaler selections and masks
	localparam int PRESC_W = 10;
	localparam logic [2:0] CSEL_STOP = 3'h0;
	localparam logic [2:0] CSEL_1    = 3'h1;
	localparam logic [2:0] CSEL_8    = 3'h2;
	localparam logic [2:0] CSEL_64   = 3'h3;
	localparam logic [2:0] CSEL_256  = 3'h4;
	localparam logic [2:0] CSEL_1024 = 3'h5;
	localparam logic [9:0] DIV_1_MASK    = 10'h000;
	localparam logic [9:0] DIV_8_MASK    = 10'h007;
	localparam logic [9:0] DIV_64_MASK   = 10'h03f;
	localparam logic [9:0] DIV_256_MASK  = 10'h0ff;
	localparam logic [9:0] DIV_1024_MASK = 10'h3ff;
endpackage

/* dspt_prescaler.sv */
/*
 * Timer tick generator: free divider with selectable ratio.
 * Assumes one clock; the tick is a one-cycle enable, never a clock.
 */
`timescale 1ns/1ps
module dspt_prescaler (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [2:0] clk_sel,
	output logic            tick
);
	import dspt_pkg::*;

	typedef struct packed {
		logic [PRESC_W-1:0] cnt;
		logic               tick;
	} dspt_presc_type;

	dspt_presc_type s;
	dspt_presc_type next_s;
	logic [PRESC_W-1:0] mask;

	// Divide ratio select; unknown codes stop the timer
	always_comb begin
		next_s = s;
		mask = DIV_1_MASK;
		case (clk_sel)
			CSEL_8:    mask = DIV_8_MASK;
			CSEL_64:   mask = DIV_64_MASK;
			CSEL_256:  mask = DIV_256_MASK;
			CSEL_1024: mask = DIV_1024_MASK;
			default:   mask = DIV_1_MASK;
		endcase
		if (clk_sel >= CSEL_1 && clk_sel <= CSEL_1024) begin
			next_s.cnt  = s.cnt + 1'b1;
			next_s.tick = (s.cnt & mask) == mask;
		end else begin
			next_s.cnt  = '0;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule

/* dspt_compare_out.sv */
/*
 * One compare output unit: waveform flip-flop and pin enable.
 * Assumes count, compare and TOP are stable values from the counter core.
 */
`timescale 1ns/1ps
module dspt_compare_out #(
	parameter bit TOGGLE_OK = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        run,
	input  wire logic [15:0] count_value,
	input  wire logic [15:0] compare_value,
	input  wire logic [15:0] top,
	input  wire logic        count_up,
	input  wire logic [1:0]  output_mode_field,
	input  wire logic        mode_sel_hi,
	input  wire logic        pin_direction_bit,
	output logic             compare_output,
	output logic             compare_output_oe
);
	import dspt_pkg::*;

	typedef struct packed {
		logic level;
		logic oe;
	} dspt_cmp_type;

	dspt_cmp_type s;
	dspt_cmp_type next_s;
	logic         inv;
	logic         toggle_mode;

	// Waveform update on each tick; extremes are forced so no stray spikes
	always_comb begin
		next_s = s;
		inv = output_mode_field == OM_INV;
		toggle_mode = TOGGLE_OK && mode_sel_hi && output_mode_field == OM_TOGGLE;
		if (run) begin
			if (output_mode_field == OM_NONINV || output_mode_field == OM_INV) begin
				if (compare_value == BOTTOM) begin
					next_s.level = inv;
				end else if (compare_value >= top) begin
					next_s.level = ~inv;
				end else if (count_value == compare_value) begin
					next_s.level = count_up ? inv : ~inv;
				end
			end else if (toggle_mode && count_value == compare_value) begin
				next_s.level = ~s.level;
			end
		end
		// Channel B treats toggle code as reserved and stays off the pin
		next_s.oe = pin_direction_bit && (output_mode_field != OM_OFF)
			&& (output_mode_field != OM_TOGGLE || toggle_mode);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign compare_output    = s.level;
	assign compare_output_oe = s.oe;
endmodule

/* dspt_timer.sv */
/*
 * Dual-slope 16-bit PWM timer with byte-wide registers behind an APB slave.
 * Assumes a single 100 MHz clock and an APB master on that clock; pins are
 * resolved outside from each output and its enable.
 */
`timescale 1ns/1ps
module dspt_timer (
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [dspt_pkg::ADDR_W-1:0] paddr,
	input  wire logic [dspt_pkg::DATA_W-1:0] pwdata,
	output logic      [dspt_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            compare_output_a,
	output logic                            compare_output_a_oe,
	output logic                            compare_output_b,
	output logic                            compare_output_b_oe
);
	import dspt_pkg::*;

	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [7:0]  temp;
		logic [7:0]  snap_hi;
		logic        snap_load;
		logic [15:0] count_value;
		logic        count_up;
		logic [15:0] cmp_a_buf;
		logic [15:0] compare_value_a;
		logic [15:0] cmp_b_buf;
		logic [15:0] compare_value_b;
		logic [15:0] capture_top_value;
		logic [3:0]  flags;
		logic [1:0]  pin_dir;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dspt_state_type;

	dspt_state_type s;
	dspt_state_type next_s;

	logic        timer_tick;
	logic [3:0]  waveform_mode_sel;
	logic        dual;
	logic        run;
	logic [15:0] top;
	logic        setup;
	logic        access;
	logic        wr;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        hit;
	logic [3:0]  flag_set;
	logic [3:0]  flag_clr;
	logic        at_top;
	logic        at_bottom;

	// Mode and TOP selection
	assign waveform_mode_sel = {s.ctrl_b[MSEL_HI_POS +: 2], s.ctrl_a[MSEL_LO_POS +: 2]};
	assign dual = waveform_mode_sel == MODE_TOP_CAP
		|| waveform_mode_sel == MODE_TOP_CMPA;
	assign top = (waveform_mode_sel == MODE_TOP_CAP) ? s.capture_top_value
		: s.compare_value_a;
	assign run = timer_tick && dual;
	assign at_top = s.count_value >= top;
	assign at_bottom = s.count_value == BOTTOM;

	// Bus phases; setup loads read data and ready, the access edge applies writes
	assign setup  = psel && !penable;
	assign access = psel && penable && s.pready;
	assign wr     = access && pwrite;
	assign wbyte  = pwdata[7:0];

	// Counter, flags, buffers and register file
	always_comb begin
		next_s = s;
		flag_set = '0;
		flag_clr = '0;
		rbyte = '0;
		hit = 1'b1;

		// Counting runs only on a tick in the dual-slope modes
		if (run) begin
			if (s.count_up) begin
				// Lowered TOP below the count still turns the slope round
				if (at_top) begin
					next_s.count_up = 1'b0;
					next_s.count_value = s.count_value - 1'b1;
				end else begin
					next_s.count_value = s.count_value + 1'b1;
				end
			end else begin
				if (at_bottom) begin
					// Turning at both ends gives a period of twice TOP ticks
					next_s.count_up = 1'b1;
					next_s.count_value = s.count_value + 1'b1;
				end else begin
					next_s.count_value = s.count_value - 1'b1;
				end
			end
			if (at_bottom) begin
				next_s.compare_value_a = s.cmp_a_buf;
				next_s.compare_value_b = s.cmp_b_buf;
				flag_set[FLAG_OVF] = 1'b1;
			end
			if (s.count_value == top) begin
				if (waveform_mode_sel == MODE_TOP_CAP) begin
					flag_set[FLAG_CAP] = 1'b1;
				end else begin
					flag_set[FLAG_CMPA] = 1'b1;
				end
			end
			// A compare above TOP is never reached, so never flags
			if (s.count_value == s.compare_value_a) begin
				flag_set[FLAG_CMPA] = 1'b1;
			end
			if (s.count_value == s.compare_value_b) begin
				flag_set[FLAG_CMPB] = 1'b1;
			end
		end

		// Setup cycle: decode, capture read data and the high-byte snapshot
		if (setup) begin
			next_s.pready = 1'b1;
			next_s.snap_load = 1'b0;
			next_s.snap_hi = s.temp;
			if (paddr == OFS_CTRL_A) begin
				rbyte = s.ctrl_a;
			end else if (paddr == OFS_CTRL_B) begin
				rbyte = s.ctrl_b;
			end else if (paddr == OFS_CNT_L) begin
				rbyte = s.count_value[7:0];
				next_s.snap_hi = s.count_value[15:8];
				next_s.snap_load = !pwrite;
			end else if (paddr == OFS_CNT_H) begin
				rbyte = s.temp;
			end else if (paddr == OFS_CMPA_L) begin
				rbyte = s.cmp_a_buf[7:0];
			end else if (paddr == OFS_CMPA_H) begin
				rbyte = s.cmp_a_buf[15:8];
			end else if (paddr == OFS_CMPB_L) begin
				rbyte = s.cmp_b_buf[7:0];
			end else if (paddr == OFS_CMPB_H) begin
				rbyte = s.cmp_b_buf[15:8];
			end else if (paddr == OFS_CAP_L) begin
				rbyte = s.capture_top_value[7:0];
				next_s.snap_hi = s.capture_top_value[15:8];
				next_s.snap_load = !pwrite;
			end else if (paddr == OFS_CAP_H) begin
				rbyte = s.temp;
			end else if (paddr == OFS_FLAGS) begin
				rbyte = {4'h0, s.flags};
			end else if (paddr == OFS_DIR) begin
				rbyte = {6'h00, s.pin_dir};
			end else begin
				hit = 1'b0;
			end
			next_s.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
			next_s.pslverr = !hit;
		end

		// Access edge: read side effect and writes
		if (access) begin
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
			if (s.snap_load) begin
				next_s.temp = s.snap_hi;
			end
		end
		if (wr) begin
			if (paddr == OFS_CTRL_A) begin
				next_s.ctrl_a = wbyte & CTRL_A_MASK;
			end else if (paddr == OFS_CTRL_B) begin
				next_s.ctrl_b = wbyte & CTRL_B_MASK;
			end else if (paddr == OFS_CNT_L) begin
				// Software write overrides the tick in the same cycle
				next_s.count_value = {s.temp, wbyte};
			end else if (paddr == OFS_CMPA_L) begin
				next_s.cmp_a_buf = {s.temp, wbyte};
				if (!dual) begin
					next_s.compare_value_a = {s.temp, wbyte};
				end
			end else if (paddr == OFS_CMPB_L) begin
				next_s.cmp_b_buf = {s.temp, wbyte};
				if (!dual) begin
					next_s.compare_value_b = {s.temp, wbyte};
				end
			end else if (paddr == OFS_CAP_L) begin
				// Capture/top has no buffer, so a new TOP acts at once
				next_s.capture_top_value = {s.temp, wbyte};
			end else if (paddr == OFS_CNT_H || paddr == OFS_CMPA_H
				|| paddr == OFS_CMPB_H || paddr == OFS_CAP_H) begin
				next_s.temp = wbyte;
			end else if (paddr == OFS_FLAGS) begin
				flag_clr = wbyte[3:0];
			end else if (paddr == OFS_DIR) begin
				next_s.pin_dir = wbyte[1:0];
			end
		end

		// A flag event in the clearing cycle survives the clear
		next_s.flags = (s.flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.ctrl_a <= CTRL_A_RST;
			s.ctrl_b <= CTRL_B_RST;
			s.count_up <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Tick source
	dspt_prescaler u_presc (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clk_sel (s.ctrl_b[CSEL_POS +: 3]),
		.tick    (timer_tick)
	);

	// Channel A may toggle; channel B treats that code as reserved
	dspt_compare_out #(.TOGGLE_OK(1'b1)) u_cmp_a (
		.ref_clk           (ref_clk),
		.rstn              (rstn),
		.run               (run),
		.count_value       (s.count_value),
		.compare_value     (s.compare_value_a),
		.top               (top),
		.count_up          (s.count_up),
		.output_mode_field (s.ctrl_a[MODE_A_POS +: 2]),
		.mode_sel_hi       (waveform_mode_sel[3]),
		.pin_direction_bit (s.pin_dir[DIR_A_POS]),
		.compare_output    (compare_output_a),
		.compare_output_oe (compare_output_a_oe)
	);

	dspt_compare_out #(.TOGGLE_OK(1'b0)) u_cmp_b (
		.ref_clk           (ref_clk),
		.rstn              (rstn),
		.run               (run),
		.count_value       (s.count_value),
		.compare_value     (s.compare_value_b),
		.top               (top),
		.count_up          (s.count_up),
		.output_mode_field (s.ctrl_a[MODE_B_POS +: 2]),
		.mode_sel_hi       (waveform_mode_sel[3]),
		.pin_direction_bit (s.pin_dir[DIR_B_POS]),
		.compare_output    (compare_output_b),
		.compare_output_oe (compare_output_b_oe)
	);

	// Bus answers straight from the state register
	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
endmodule

/* dspt_timer_sva.sv */
/*
 * Checker on the timer's APB and pin ports.
 * Assumes a bind onto dspt_timer and sees its ports only.
 */
`timescale 1ns/1ps
module dspt_timer_sva
	import dspt_pkg::*;
(
	input wire logic                        ref_clk,
	input wire logic                        rstn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [dspt_pkg::ADDR_W-1:0] paddr,
	input wire logic [dspt_pkg::DATA_W-1:0] pwdata,
	input wire logic [dspt_pkg::DATA_W-1:0] prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        compare_output_a,
	input wire logic                        compare_output_a_oe,
	input wire logic                        compare_output_b,
	input wire logic                        compare_output_b_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic [1:0] dir_q;
	logic       bad_a;
	// Unmapped: past the last register or not word aligned
	assign bad_a = (paddr > OFS_DIR) || (paddr[1:0] != 2'h0);
	// Direction bits as software last wrote them
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			dir_q <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == OFS_DIR)
			dir_q <= pwdata[1:0];
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	AST_READY: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	AST_ONE_SHOT: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	AST_IN_ACCESS: assert property (pready |-> s_access)
		else $error("ready outside access");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_UNMAPPED: assert property ((s_setup ##0 bad_a && !pwrite) |=> pslverr && prdata == '0)
		else $error("unmapped read not refused");
	AST_MAPPED: assert property ((s_setup ##0 !bad_a) |=> !pslverr)
		else $error("mapped access refused");
	AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_OE_A: assert property (!dir_q[0] && !$past(dir_q[0]) |-> !compare_output_a_oe)
		else $error("pin a driven as input");
	AST_OE_B: assert property (!dir_q[1] && !$past(dir_q[1]) |-> !compare_output_b_oe)
		else $error("pin b driven as input");
endmodule
bind dspt_timer dspt_timer_sva chk_u (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .compare_output_a, .compare_output_a_oe,
	.compare_output_b, .compare_output_b_oe);

/* dspt_apb_cpu.sv */
/*
 * APB master standing in for the CPU side of the timer.
 * Assumes the timer answers on the shared ref_clk.
 */
`timescale 1ns/1ps
module dspt_apb_cpu (
	input  wire logic [dspt_pkg::DATA_W-1:0] prdata,
	input  wire logic                        ref_clk,
	input  wire logic                        pready,
	input  wire logic                        pslverr,
	output logic                             psel,
	output logic                             penable,
	output logic                             pwrite,
	output logic      [dspt_pkg::ADDR_W-1:0] paddr,
	output logic      [dspt_pkg::DATA_W-1:0] pwdata
);
	import dspt_pkg::*;
	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hff;
		pwdata = 32'h0;
	end
	// One transfer; a single caller, so the temp byte is never shared mid-pair
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Idle bus must not show stale values
		pwdata <= ~{24'h0, d};
	endtask
	// High byte first, so the low write commits both
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		logic [7:0] r;
		logic       e;
		xfer(1'b1, a + 8'h04, v[15:8], r, e);
		xfer(1'b1, a, v[7:0], r, e);
	endtask
endmodule

/* dual_slope_pwm_timer16_tb_top.sv */
/*
 * Testbench: register access sequences and PWM pin measurements.
 * Assumes the CPU model and the checker bind are compiled alongside.
 */
`timescale 1ns/1ps
module dual_slope_pwm_timer16_tb_top;
	import dspt_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        compare_output_a, compare_output_a_oe, pin_a;
	logic        compare_output_b, compare_output_b_oe, pin_b;
	logic [7:0]  r;
	logic        e;
	logic [7:0]  rst_a[5] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CNT_L, OFS_FLAGS, OFS_DIR};
	int          divs[5] = '{1, 8, 64, 256, 1024};
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          ones_a, ones_b, edges_a;
	always #5 ref_clk = ~ref_clk;
	// Pins with pull-ups when not driven
	assign pin_a = compare_output_a_oe ? compare_output_a : 1'b1;
	assign pin_b = compare_output_b_oe ? compare_output_b : 1'b1;
	dspt_timer dut_u (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .compare_output_a, .compare_output_a_oe, .compare_output_b,
		.compare_output_b_oe);
	dspt_apb_cpu cpu_u (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
		.paddr, .pwdata);
	task automatic chk8(input logic [7:0] a, input logic [7:0] x, input logic [7:0] g);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED reg %h exp %h got %h", a, x, g);
		end
	endtask
	task automatic chk_n(input string nm, input int x, input int g);
		tests_run++;
		if (g != x) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %0d got %0d", nm, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu_u.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		cpu_u.xfer(1'b0, a, 8'h00, r, e);
		chk8(a, x, r);
	endtask
	// High cycles on the pins and rising edges on pin a over n cycles
	task automatic meas(input int n);
		logic pa;
		ones_a = 0;
		ones_b = 0;
		edges_a = 0;
		@(negedge ref_clk);
		pa = pin_a;
		repeat (n) begin
			@(negedge ref_clk);
			if (pin_a === 1'b1) ones_a++;
			if (pin_b === 1'b1) ones_b++;
			if (pin_a === 1'b1 && pa === 1'b0) edges_a++;
			pa = pin_a;
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole run is about 49k cycles
	initial begin
		#1000000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (rst_a[i]) rd(rst_a[i], 8'h00);
		cpu_u.xfer(1'b0, 8'h30, 8'h00, r, e);
		chk8(8'h30, 8'h01, {7'h0, e});
		// Temp byte: low read copies high, compare reads bypass it
		cpu_u.wr16(OFS_CNT_L, 16'h01ff);
		rd(OFS_CNT_L, 8'hff);
		rd(OFS_CNT_H, 8'h01);
		cpu_u.wr16(OFS_CMPA_L, 16'h2a55);
		rd(OFS_CNT_L, 8'hff);
		rd(OFS_CMPA_H, 8'h2a);
		rd(OFS_CNT_H, 8'h01);
		// One high byte shared by several low writes
		wr(OFS_CAP_H, 8'h00);
		wr(OFS_CAP_L, 8'h06);
		wr(OFS_CMPA_L, 8'h02);
		wr(OFS_CMPB_L, 8'h01);
		wr(OFS_CNT_L, 8'h00);
		rd(OFS_CMPA_H, 8'h00);
		// Mode 8, TOP 6: A non-inverted at 2, B inverted at 1
		wr(OFS_CTRL_A, 8'hb0);
		wr(OFS_DIR, 8'h03);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CTRL_B, 8'h10 | 8'(i + 1));
			repeat (12 * divs[i] + 8) @(posedge ref_clk);
			meas(24 * divs[i]);
			chk_n("edges a", 2, edges_a);
			chk_n("high a", 8 * divs[i], ones_a);
			chk_n("high b", 20 * divs[i], ones_b);
		end
		chk8(OFS_DIR, 8'h01, {7'h0, compare_output_a_oe});
		wr(OFS_CTRL_B, 8'h10);
		rd(OFS_FLAGS, 8'h0f);
		wr(OFS_FLAGS, 8'h0f);
		rd(OFS_FLAGS, 8'h00);
		// Extremes: A at BOTTOM, B above TOP, loaded at BOTTOM
		wr(OFS_CMPA_L, 8'h00);
		wr(OFS_CMPB_L, 8'h08);
		wr(OFS_CTRL_B, 8'h11);
		repeat (30) @(posedge ref_clk);
		wr(OFS_FLAGS, 8'h0f);
		repeat (30) @(posedge ref_clk);
		meas(24);
		chk_n("high a", 0, ones_a);
		chk_n("high b", 0, ones_b);
		wr(OFS_CTRL_B, 8'h10);
		rd(OFS_FLAGS, 8'h0b);
		// Mode 9, TOP from compare A, A toggles
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_CNT_L, 8'h00);
		wr(OFS_CMPA_L, 8'h05);
		wr(OFS_CTRL_A, 8'h51);
		wr(OFS_FLAGS, 8'h0f);
		wr(OFS_CTRL_B, 8'h11);
		repeat (30) @(posedge ref_clk);
		meas(40);
		chk_n("edges a", 2, edges_a);
		chk_n("high a", 20, ones_a);
		chk8(OFS_DIR, 8'h00, {7'h0, compare_output_b_oe});
		wr(OFS_CTRL_B, 8'h10);
		rd(OFS_FLAGS, 8'h03);
		wr(OFS_DIR, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk8(OFS_DIR, 8'h00, {7'h0, compare_output_a_oe});
		close_out();
	end
endmodule
